// File: src/sdadc_pkg.sv
`default_nettype none
package sdadc_pkg;
    localparam logic [3:0] ADDR_CTRL_ZERO = 4'h0;
    localparam logic [3:0] ADDR_CTRL_ONE  = 4'h1;
    localparam logic [3:0] ADDR_CLK_DIV   = 4'h2;
    localparam logic [3:0] ADDR_RES_LOW   = 4'h3;
    localparam logic [3:0] ADDR_RES_MID   = 4'h4;
    localparam logic [3:0] ADDR_RES_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_POWER     = 4'h6;
    localparam logic [3:0] ADDR_INPUT_SEL = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CTRL  = 4'h8;

    localparam int CTRL0_RESET_BIT = 7;
    localparam int CTRL0_SLEEP_BIT = 6;
    localparam int CTRL0_OFF_BIT   = 5;
    localparam int CTRL0_OSR_LSB   = 2;
    localparam int CTRL1_SAMPLE_DOUBLING_FACTOR_LSB  = 5;
    localparam int CTRL1_HOLD_BIT  = 2;
    localparam int CTRL1_EOC_BIT   = 1;
    localparam int POWER_REG_BIT   = 7;
    localparam int INSEL_NEG_LSB   = 4;
    localparam int IRQ_GLOBAL_BIT  = 0;
    localparam int IRQ_CONV_BIT    = 1;
    localparam int IRQ_FLAG_BIT    = 2;

    localparam logic [7:0] CTRL_ZERO_RST = 8'h20;
    localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
    localparam logic [7:0] CLK_DIV_RST   = 8'h00;
    localparam logic [7:0] POWER_RST     = 8'h00;
    localparam logic [7:0] INPUT_SEL_RST = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;

    localparam logic [4:0]  MCLK_BYPASS   = 5'h1F;
    localparam logic [4:0]  ADCK_DIV_SLOW = 5'h1E;
    localparam logic [4:0]  ADCK_DIV_FAST = 5'h0C;
    localparam logic [14:0] OSR_MAX       = 15'h4000;
    localparam logic [3:0]  TSENSE_SEL    = 4'h7;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_RESET, MODE_POWER_DOWN} mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic        done;
        logic [23:0] data;
    } conv_t;

    typedef struct packed {
        logic bandgap;
        logic regulator;
        logic amplifier;
        logic converter;
        logic temp_sensor;
        logic filter_on;
        logic filter_reset;
    } power_t;

    typedef struct packed {
        logic        mclk_tick;
        logic        adck_tick;
        logic        sample_doubling_factor_double;
        logic [14:0] osr_value;
    } clocks_t;

    typedef struct packed {
        logic        power_off;
        logic        sleep_sel;
        logic        soft_reset;
        logic [2:0]  osr_sel;
        logic [2:0]  clock_sample_doubling_factor_sel;
        logic        hold;
        logic        eoc;
        logic [4:0]  clock_div;
        logic        regulator_en;
        logic [3:0]  pos_sel;
        logic [3:0]  neg_sel;
        logic        global_irq_en;
        logic        conv_irq_en;
        logic        irq_flag;
        logic [23:0] result;
        logic        armed;
        logic [5:0]  mdiv_cnt;
        logic [4:0]  ndiv_cnt;
        logic [7:0]  rdata;
        power_t      power;
        clocks_t     clocks;
        logic        irq;
    } state_t;

    function automatic mode_t decode_mode(input logic off, input logic slp, input logic rst);
        if (off) begin
            return MODE_POWER_DOWN;
        end else if (slp) begin
            return MODE_SLEEP;
        end else if (rst) begin
            return MODE_RESET;
        end
        return MODE_NORMAL;
    endfunction
endpackage
`default_nettype wire

// File: src/sdadc_ctrl.sv
// Summary of operation
// - Power-off bit 1 switches converter off
// - Power-off overrides sleep and filter reset
// - Oversample code halves ratio 16384 to 128
// - Sample_doubling_factor field picks factor and divide 30/12
// - Sample_doubling_factor two doubles samples, one is low-latency
// - Hold bit freezes result bytes
// - While held, no interrupt, no flag change
// - End flag cleared only by software
// - End flag set after each accepted conversion while not held
// - Conversion end sets interrupt request flag
// - Divider: sys/2/(code+1), code 31 bypasses
// - Power-down: analog off, bandgap follows regulator
// - Sleep: bandgap, amplifier, filter on; converter and sensor off
// - Filter reset bit gives reset mode
// - Reset bit pulse starts conversions
// - Without hold, results overwrite continuously
// - Temperature sensor on only when selected
// - Unimplemented bits read as zero
// - Filter reset aborts and blocks conversions
// - Sleep keeps amplifier and bandgap powered
// - Result readable as three bytes
`timescale 1ns/1ps
`default_nettype none
module sdadc_ctrl (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire sdadc_pkg::reg_req_t REG_REQ,
    output var  logic [7:0]          RDATA,
    input  wire sdadc_pkg::conv_t    CONV,
    output var  sdadc_pkg::power_t   POWER,
    output var  sdadc_pkg::clocks_t  CLOCKS,
    output var  logic                IRQ
);
    sdadc_pkg::state_t q;
    sdadc_pkg::state_t next_q;
    sdadc_pkg::mode_t  mode;
    logic              accept;
    logic              temp_selected;
    logic [4:0]        adck_div;

    assign mode = sdadc_pkg::decode_mode(q.power_off, q.sleep_sel, q.soft_reset);
    // Conversions count only once started and in normal mode
    assign accept        = CONV.done && q.armed && (mode == sdadc_pkg::MODE_NORMAL);
    assign temp_selected = (q.pos_sel == sdadc_pkg::TSENSE_SEL) ||
                           (q.neg_sel == sdadc_pkg::TSENSE_SEL);
    // Reserved sample_doubling_factor codes ignore bit 0
    assign adck_div = q.clock_sample_doubling_factor_sel[1] ? sdadc_pkg::ADCK_DIV_FAST : sdadc_pkg::ADCK_DIV_SLOW;

    always_comb begin
        next_q       = q;
        next_q.rdata = 8'h00;
        if (q.power_off || q.soft_reset) begin
            next_q.armed = 1'b0;
        end
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                sdadc_pkg::ADDR_CTRL_ZERO: begin
                    if (q.soft_reset && !REG_REQ.wdata[sdadc_pkg::CTRL0_RESET_BIT] &&
                        !REG_REQ.wdata[sdadc_pkg::CTRL0_OFF_BIT]) begin
                        next_q.armed = 1'b1;
                    end
                    next_q.soft_reset = REG_REQ.wdata[sdadc_pkg::CTRL0_RESET_BIT];
                    next_q.sleep_sel  = REG_REQ.wdata[sdadc_pkg::CTRL0_SLEEP_BIT];
                    next_q.power_off  = REG_REQ.wdata[sdadc_pkg::CTRL0_OFF_BIT];
                    next_q.osr_sel    = REG_REQ.wdata[sdadc_pkg::CTRL0_OSR_LSB +: 3];
                end
                sdadc_pkg::ADDR_CTRL_ONE: begin
                    next_q.clock_sample_doubling_factor_sel = REG_REQ.wdata[sdadc_pkg::CTRL1_SAMPLE_DOUBLING_FACTOR_LSB +: 3];
                    next_q.hold           = REG_REQ.wdata[sdadc_pkg::CTRL1_HOLD_BIT];
                    next_q.eoc            = REG_REQ.wdata[sdadc_pkg::CTRL1_EOC_BIT];
                end
                sdadc_pkg::ADDR_CLK_DIV: begin
                    next_q.clock_div = REG_REQ.wdata[4:0];
                end
                sdadc_pkg::ADDR_POWER: begin
                    next_q.regulator_en = REG_REQ.wdata[sdadc_pkg::POWER_REG_BIT];
                end
                sdadc_pkg::ADDR_INPUT_SEL: begin
                    next_q.pos_sel = REG_REQ.wdata[3:0];
                    next_q.neg_sel = REG_REQ.wdata[sdadc_pkg::INSEL_NEG_LSB +: 4];
                end
                sdadc_pkg::ADDR_IRQ_CTRL: begin
                    next_q.global_irq_en = REG_REQ.wdata[sdadc_pkg::IRQ_GLOBAL_BIT];
                    next_q.conv_irq_en   = REG_REQ.wdata[sdadc_pkg::IRQ_CONV_BIT];
                    next_q.irq_flag      = REG_REQ.wdata[sdadc_pkg::IRQ_FLAG_BIT];
                end
                default: begin
                    next_q.rdata = 8'h00;
                end
            endcase
        end
        if (accept && !q.hold) begin
            next_q.result   = CONV.data;
            next_q.eoc      = 1'b1;
            next_q.irq_flag = 1'b1;
        end
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                sdadc_pkg::ADDR_CTRL_ZERO: next_q.rdata = {q.soft_reset, q.sleep_sel,
                                                           q.power_off, q.osr_sel, 2'h0};
                sdadc_pkg::ADDR_CTRL_ONE:  next_q.rdata = {q.clock_sample_doubling_factor_sel, 2'h0, q.hold,
                                                           q.eoc, 1'h0};
                sdadc_pkg::ADDR_CLK_DIV:   next_q.rdata = {3'h0, q.clock_div};
                sdadc_pkg::ADDR_RES_LOW:   next_q.rdata = q.result[7:0];
                sdadc_pkg::ADDR_RES_MID:   next_q.rdata = q.result[15:8];
                sdadc_pkg::ADDR_RES_HIGH:  next_q.rdata = q.result[23:16];
                sdadc_pkg::ADDR_POWER:     next_q.rdata = {q.regulator_en, 7'h00};
                sdadc_pkg::ADDR_INPUT_SEL: next_q.rdata = {q.neg_sel, q.pos_sel};
                sdadc_pkg::ADDR_IRQ_CTRL:  next_q.rdata = {5'h00, q.irq_flag, q.conv_irq_en,
                                                           q.global_irq_en};
                default:                   next_q.rdata = 8'h00;
            endcase
        end
        next_q.power.regulator = q.regulator_en;
        unique case (mode)
            sdadc_pkg::MODE_POWER_DOWN: begin
                next_q.power.bandgap      = q.regulator_en;
                next_q.power.amplifier    = 1'b0;
                next_q.power.converter    = 1'b0;
                next_q.power.temp_sensor  = 1'b0;
                next_q.power.filter_on    = 1'b0;
                next_q.power.filter_reset = 1'b0;
            end
            sdadc_pkg::MODE_SLEEP: begin
                next_q.power.bandgap      = 1'b1;
                next_q.power.amplifier    = 1'b1;
                next_q.power.converter    = 1'b0;
                next_q.power.temp_sensor  = 1'b0;
                next_q.power.filter_on    = 1'b1;
                next_q.power.filter_reset = 1'b0;
            end
            sdadc_pkg::MODE_RESET, sdadc_pkg::MODE_NORMAL: begin
                next_q.power.bandgap      = 1'b1;
                next_q.power.amplifier    = 1'b1;
                next_q.power.converter    = 1'b1;
                next_q.power.temp_sensor  = temp_selected;
                next_q.power.filter_on    = 1'b1;
                next_q.power.filter_reset = (mode == sdadc_pkg::MODE_RESET);
            end
        endcase
        next_q.clocks.osr_value   = sdadc_pkg::OSR_MAX >> q.osr_sel;
        next_q.clocks.sample_doubling_factor_double = !q.clock_sample_doubling_factor_sel[2];
        next_q.clocks.mclk_tick   = 1'b0;
        next_q.clocks.adck_tick   = 1'b0;
        // Dividers idle in power-down to save toggling
        if (mode == sdadc_pkg::MODE_POWER_DOWN) begin
            next_q.mdiv_cnt = 6'h00;
            next_q.ndiv_cnt = 5'h00;
        end else begin
            if (q.clock_div == sdadc_pkg::MCLK_BYPASS) begin
                next_q.mdiv_cnt         = 6'h00;
                next_q.clocks.mclk_tick = 1'b1;
            end else if (q.mdiv_cnt >= {q.clock_div, 1'b1}) begin
                next_q.mdiv_cnt         = 6'h00;
                next_q.clocks.mclk_tick = 1'b1;
            end else begin
                next_q.mdiv_cnt = q.mdiv_cnt + 6'h01;
            end
            if (q.clocks.mclk_tick) begin
                if (q.ndiv_cnt >= adck_div - 5'h01) begin
                    next_q.ndiv_cnt         = 5'h00;
                    next_q.clocks.adck_tick = 1'b1;
                end else begin
                    next_q.ndiv_cnt = q.ndiv_cnt + 5'h01;
                end
            end
        end
        next_q.irq = q.irq_flag && q.global_irq_en && q.conv_irq_en;
        if (RST) begin
            next_q                = '0;
            {next_q.soft_reset, next_q.sleep_sel, next_q.power_off,
             next_q.osr_sel}      = sdadc_pkg::CTRL_ZERO_RST[7:2];
            {next_q.clock_sample_doubling_factor_sel, next_q.hold,
             next_q.eoc}          = {sdadc_pkg::CTRL_ONE_RST[7:5], sdadc_pkg::CTRL_ONE_RST[2:1]};
            next_q.clock_div      = sdadc_pkg::CLK_DIV_RST[4:0];
            next_q.regulator_en   = sdadc_pkg::POWER_RST[7];
            {next_q.neg_sel, next_q.pos_sel} = sdadc_pkg::INPUT_SEL_RST;
            {next_q.irq_flag, next_q.conv_irq_en,
             next_q.global_irq_en} = sdadc_pkg::IRQ_CTRL_RST[2:0];
            next_q.clocks.osr_value   = sdadc_pkg::OSR_MAX;
            next_q.clocks.sample_doubling_factor_double = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        q <= next_q;
    end

    assign RDATA  = q.rdata;
    assign POWER  = q.power;
    assign CLOCKS = q.clocks;
    assign IRQ    = q.irq;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence conv_taken;
        accept && !q.hold;
    endsequence

    sequence start_write;
        REG_REQ.wr && REG_REQ.addr == sdadc_pkg::ADDR_CTRL_ZERO && q.soft_reset &&
        !REG_REQ.wdata[sdadc_pkg::CTRL0_RESET_BIT] && !REG_REQ.wdata[sdadc_pkg::CTRL0_OFF_BIT];
    endsequence

    power_down_a: assert property (q.power_off |=> !POWER.converter && !POWER.amplifier &&
        !POWER.filter_on && !POWER.temp_sensor && POWER.bandgap == $past(q.regulator_en))
        else $error("converter powered while off");
    sleep_power_a: assert property (mode == sdadc_pkg::MODE_SLEEP |=> POWER.bandgap &&
        POWER.amplifier && POWER.filter_on && !POWER.converter && !POWER.temp_sensor)
        else $error("sleep power set wrong");
    reset_filter_a: assert property (mode == sdadc_pkg::MODE_RESET |=> POWER.filter_reset &&
        POWER.converter) else $error("filter not held in reset");
    osr_decode_a: assert property (1'b1 |=>
        CLOCKS.osr_value == (sdadc_pkg::OSR_MAX >> $past(q.osr_sel)))
        else $error("oversample ratio wrong");
    sample_doubling_factor_select_a: assert property (1'b1 |=>
        CLOCKS.sample_doubling_factor_double == !$past(q.clock_sample_doubling_factor_sel[2])) else $error("sample_doubling_factor factor wrong");
    hold_freeze_a: assert property (q.hold |=> $stable(q.result))
        else $error("held result changed");
    hold_quiet_a: assert property (q.hold && !REG_REQ.wr |=> $stable(q.eoc) &&
        $stable(q.irq_flag)) else $error("flag moved while held");
    conv_store_a: assert property (conv_taken |=> q.eoc && q.irq_flag &&
        q.result == $past(CONV.data)) else $error("conversion not stored");
    start_arm_a: assert property (start_write |=> q.armed ##1 !POWER.filter_reset)
        else $error("reset pulse did not start");
    bypass_tick_a: assert property ((q.clock_div == sdadc_pkg::MCLK_BYPASS &&
        mode != sdadc_pkg::MODE_POWER_DOWN)[*2] |=> CLOCKS.mclk_tick)
        else $error("bypass clock not passed");
    unused_zero_a: assert property (REG_REQ.rd && REG_REQ.addr == sdadc_pkg::ADDR_CTRL_ONE |=>
        RDATA[4:3] == 2'h0 && RDATA[0] == 1'b0) else $error("unused bits not zero");
    irq_out_a: assert property (q.irq_flag && q.global_irq_en && q.conv_irq_en |=> IRQ)
        else $error("interrupt not raised");
    irq_low_a: assert property (!q.irq_flag |=> !IRQ)
        else $error("interrupt without request flag");
    eoc_sticky_a: assert property (q.eoc && !(REG_REQ.wr &&
        REG_REQ.addr == sdadc_pkg::ADDR_CTRL_ONE) |=> q.eoc)
        else $error("end flag cleared by hardware");
    flag_sticky_a: assert property (q.irq_flag && !(REG_REQ.wr &&
        REG_REQ.addr == sdadc_pkg::ADDR_IRQ_CTRL) |=> q.irq_flag)
        else $error("request flag cleared by hardware");
    disarm_a: assert property ((q.soft_reset || q.power_off) &&
        !(REG_REQ.wr && REG_REQ.addr == sdadc_pkg::ADDR_CTRL_ZERO) |=> !q.armed)
        else $error("conversion armed during reset");
    refuse_a: assert property (CONV.done && !REG_REQ.wr &&
        (!q.armed || mode != sdadc_pkg::MODE_NORMAL) |=>
        $stable(q.result) && $stable(q.eoc) && $stable(q.irq_flag))
        else $error("result taken while not converting");
    normal_power_a: assert property (mode == sdadc_pkg::MODE_NORMAL |=>
        POWER.converter && POWER.filter_on && !POWER.filter_reset &&
        POWER.amplifier && POWER.bandgap) else $error("normal power set wrong");
    temp_power_a: assert property (mode == sdadc_pkg::MODE_NORMAL |=>
        POWER.temp_sensor == $past(temp_selected))
        else $error("sensor power wrong");
    reg_follow_a: assert property (1'b1 |=>
        POWER.regulator == $past(q.regulator_en))
        else $error("regulator enable not followed");
    result_read_a: assert property (REG_REQ.rd && REG_REQ.addr == sdadc_pkg::ADDR_RES_MID |=>
        RDATA == $past(q.result[15:8])) else $error("middle byte read wrong");
    read_idle_a: assert property (!REG_REQ.rd |=> RDATA == 8'h00)
        else $error("read data not cleared");
    ctrl0_zero_a: assert property (REG_REQ.rd &&
        REG_REQ.addr == sdadc_pkg::ADDR_CTRL_ZERO |=> RDATA[1:0] == 2'h0)
        else $error("low control bits not zero");
    mclk_off_a: assert property (mode == sdadc_pkg::MODE_POWER_DOWN |=>
        !CLOCKS.mclk_tick && !CLOCKS.adck_tick)
        else $error("clock ticks while powered off");
    div_tick_a: assert property (mode != sdadc_pkg::MODE_POWER_DOWN &&
        q.clock_div != sdadc_pkg::MCLK_BYPASS &&
        q.mdiv_cnt < {q.clock_div, 1'b1} |=> !CLOCKS.mclk_tick)
        else $error("master tick before terminal count");
endmodule
`default_nettype wire

// File: test/sinc_filter_model.sv
`timescale 1ns/1ps
`default_nettype none
module sinc_filter_model (
    input  wire logic               clk,
    input  wire sdadc_pkg::power_t  power,
    input  wire sdadc_pkg::clocks_t clocks,
    input  wire logic               fire,
    input  wire logic [23:0]        sample,
    input  wire logic [3:0]         lag,
    output var  sdadc_pkg::conv_t   conv
);
    logic             pending = 1'b0;
    logic [3:0]       left    = 4'h0;
    logic [23:0]      held    = 24'h000000;
    sdadc_pkg::conv_t word    = '0;

    assign conv = word;

    always @(posedge clk) begin
        word.done <= 1'b0;
        // Outside a result the data lines toggle, so stale values never pass
        word.data <= ~word.data;
        if (power.filter_reset || !power.filter_on) begin
            pending <= 1'b0;
        end else if (fire) begin
            pending <= 1'b1;
            left    <= lag;
            held    <= sample;
        end else if (pending && (left == 4'h0)) begin
            word.done <= 1'b1;
            word.data <= held;
            pending   <= 1'b0;
        end else if (pending && clocks.adck_tick) begin
            left <= left - 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: test/sigma_delta_adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_adc_control_bench;
    logic clk;
    logic rst;
    sdadc_pkg::reg_req_t req;
    logic [7:0]          rdata;
    sdadc_pkg::conv_t    conv;
    sdadc_pkg::power_t   power;
    sdadc_pkg::clocks_t  clocks;
    logic                irq;
    logic                fire;
    logic [23:0]         sample;
    logic [3:0]          lag;
    int                  num_errors;
    int                  n_checks;

    sdadc_ctrl dut (.CLK(clk), .RST(rst), .REG_REQ(req), .RDATA(rdata), .CONV(conv),
        .POWER(power), .CLOCKS(clocks), .IRQ(irq));
    sinc_filter_model far_end (.clk(clk), .power(power), .clocks(clocks), .fire(fire),
        .sample(sample), .lag(lag), .conv(conv));

    always #50 clk = ~clk;

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) begin
            req.addr <= a;
            req.wdata <= d;
            req.wr <= 1'b1;
        end
        @(posedge clk) req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) begin
            req.addr <= a;
            req.rd <= 1'b1;
        end
        @(posedge clk) req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_check(input string name, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(name, {16'h0000, d}, {16'h0000, e});
    endtask

    task automatic result_check(input logic [23:0] e);
        logic [7:0] l;
        logic [7:0] m;
        logic [7:0] h;
        rd(sdadc_pkg::ADDR_RES_LOW, l);
        rd(sdadc_pkg::ADDR_RES_MID, m);
        rd(sdadc_pkg::ADDR_RES_HIGH, h);
        check("result", {h, m, l}, e);
    endtask

    // Skips two ticks so a divider change has settled before timing
    task automatic gap(input logic adck, output int n);
        int k;
        n = 0;
        for (k = 0; k < 3; k++) begin
            n = 0;
            tick();
            while (!(adck ? clocks.adck_tick : clocks.mclk_tick) && n < 200) begin
                tick();
                n++;
            end
        end
        n++;
    endtask

    task automatic shot(input logic [23:0] d, input logic [3:0] l);
        int k;
        @(posedge clk) begin
            fire <= 1'b1;
            sample <= d;
            lag <= l;
        end
        @(posedge clk) fire <= 1'b0;
        for (k = 0; k < 400 && conv.done !== 1'b1; k++) tick();
        repeat (3) tick();
    endtask

    task automatic t_reset_and_bits();
        check("power", power, 7'h00);
        check("osr", clocks.osr_value, 15'h4000);
        check("irq", irq, 1'b0);
        rd_check("ctrl0", sdadc_pkg::ADDR_CTRL_ZERO, 8'h20);
        rd_check("res", sdadc_pkg::ADDR_RES_HIGH, 8'h00);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'hFF);
        rd_check("ctrl0", sdadc_pkg::ADDR_CTRL_ZERO, 8'hFC);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'hFF);
        rd_check("ctrl1", sdadc_pkg::ADDR_CTRL_ONE, 8'hE6);
        wr(sdadc_pkg::ADDR_CLK_DIV, 8'hFF);
        rd_check("clkdiv", sdadc_pkg::ADDR_CLK_DIV, 8'h1F);
        wr(sdadc_pkg::ADDR_RES_LOW, 8'hAA);
        rd_check("res", sdadc_pkg::ADDR_RES_LOW, 8'h00);
        rd_check("unmapped", 4'hF, 8'h00);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h20);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
    endtask

    task automatic t_rates();
        int i;
        int n;
        for (i = 0; i < 8; i++) begin
            wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h20 | 8'(i << 2));
            repeat (2) tick();
            check("osr", clocks.osr_value, 15'h4000 >> i);
        end
        // Dividers idle while powered off
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h00);
        // code 0 is nearest 4 MHz from this clock
        wr(sdadc_pkg::ADDR_CLK_DIV, 8'h00);
        gap(1'b0, n);
        check("mclk0", n, 2);
        wr(sdadc_pkg::ADDR_CLK_DIV, 8'h05);
        gap(1'b0, n);
        check("mclk5", n, 12);
        wr(sdadc_pkg::ADDR_CLK_DIV, 8'h1F);
        gap(1'b0, n);
        check("mclk31", n, 1);
        for (i = 0; i < 4; i++) begin
            wr(sdadc_pkg::ADDR_CTRL_ONE, 8'(i << 6));
            gap(1'b1, n);
            check("sample_doubling_factor", clocks.sample_doubling_factor_double, !i[1]);
            check("adck", n, i[0] ? 12 : 30);
        end
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h20);
        gap(1'b1, n);
        check("adck_rsv", n, 30);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
    endtask

    task automatic t_modes();
        int i;
        sdadc_pkg::power_t p;
        logic [6:0] m;
        for (i = 0; i < 16; i++) begin
            wr(sdadc_pkg::ADDR_POWER, {i[3], 7'h00});
            wr(sdadc_pkg::ADDR_INPUT_SEL, i[3] ? 8'h70 : 8'h00);
            wr(sdadc_pkg::ADDR_CTRL_ZERO, {i[0], i[1], i[2], 5'h00});
            repeat (3) tick();
            p = '0;
            p.regulator = i[3];
            p.bandgap = i[2] ? i[3] : 1'b1;
            if (!i[2]) begin
                p.amplifier = 1'b1;
                p.filter_on = 1'b1;
                p.converter = !i[1];
                p.temp_sensor = !i[1] && i[3];
                p.filter_reset = !i[1] && i[0];
            end
            m = (!i[2] && !i[1] && i[0]) ? 7'h7D : 7'h7F;
            check("power", power & m, p & m);
        end
    endtask

    task automatic t_convert();
        // Drop the reset bit while off, so no start edge is seen
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h20);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h00);
        shot(24'h123456, 4'h0);
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
        // software reset pulse, then both enables
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h80);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h00);
        wr(sdadc_pkg::ADDR_IRQ_CTRL, 8'h03);
        shot(24'hA1B2C3, 4'h0);
        result_check(24'hA1B2C3);
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h02);
        check("irq", irq, 1'b1);
        rd_check("flag", sdadc_pkg::ADDR_IRQ_CTRL, 8'h07);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h04);
        wr(sdadc_pkg::ADDR_IRQ_CTRL, 8'h03);
        shot(24'h5E6F70, 4'h2);
        result_check(24'hA1B2C3);
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h04);
        check("irq", irq, 1'b0);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
        shot(24'hFEDCBA, 4'h0);
        result_check(24'hFEDCBA);
        repeat (20) tick();
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h02);
        wr(sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h40);
        shot(24'h0F0F0F, 4'h1);
        rd_check("eoc", sdadc_pkg::ADDR_CTRL_ONE, 8'h00);
        result_check(24'hFEDCBA);
        wr(sdadc_pkg::ADDR_CTRL_ZERO, 8'h20);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        fire = 1'b0;
        sample = 24'h000000;
        lag = 4'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        tick();
        t_reset_and_bits();
        t_rates();
        t_modes();
        t_convert();
        tally_and_finish();
    end

    initial begin
        #(30000 * 100);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
